// ===== core/pdm_event_summary.sv
/*
  Registered summary of five enabled status groups.
  Assumes group status and enable vectors come from pclk-domain logic.
*/
`timescale 1ns/10ps
module pdm_event_summary
  import pdm_pkg::*;
#(
  parameter int GW = PDM_GRP_W
) (
  // Clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // Group status and enables
  input  wire logic [GW-1:0]        tx_status,
  input  wire logic [GW-1:0]        tx_enable,
  input  wire logic [GW-1:0]        rx_status,
  input  wire logic [GW-1:0]        rx_enable,
  input  wire logic [GW-1:0]        rx_err_status,
  input  wire logic [GW-1:0]        rx_err_enable,
  input  wire logic [GW-1:0]        pm_status,
  input  wire logic [GW-1:0]        pm_enable,
  input  wire logic [GW-1:0]        sop_status,
  input  wire logic [GW-1:0]        sop_enable,
  // Summary
  output logic      [PDM_SUM_W-1:0] summary
);

  logic [PDM_SUM_W-1:0] summary_r;
  logic [PDM_SUM_W-1:0] summary_nxt;

  // Any bit both set and enabled
  function automatic logic any_enabled(input logic [GW-1:0] st, input logic [GW-1:0] en);
    return |(st & en);
  endfunction

  // ----------------------------------------
  // Summary decode
  // ----------------------------------------
  always_comb begin
    summary_nxt                 = PDM_RST_SUM;
    summary_nxt[PDM_SUM_TX]     = any_enabled(tx_status, tx_enable);
    summary_nxt[PDM_SUM_RX]     = any_enabled(rx_status, rx_enable);
    summary_nxt[PDM_SUM_RX_ERR] = any_enabled(rx_err_status, rx_err_enable);
    summary_nxt[PDM_SUM_PM]     = any_enabled(pm_status, pm_enable);
    summary_nxt[PDM_SUM_SOP]    = any_enabled(sop_status, sop_enable);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      summary_r <= PDM_RST_SUM;
    end else begin
      summary_r <= summary_nxt;
    end
  end

  assign summary = summary_r;

endmodule

// ===== core/pdm_pkg.sv
/*
  Shared constants for the receive head-pointer flags and MAC event summary block:
  register indices, field positions, reset values and pointer geometry.
  Assumes a single pclk domain and an APB master that addresses each register
  at four times its index.
*/
package pdm_pkg;

  // ----------------------------------------
  // Geometry and bus widths
  // ----------------------------------------
  localparam int PDM_PTR_W  = 7;
  localparam int PDM_ADDR_W = 16;
  localparam int PDM_DATA_W = 32;
  localparam int PDM_GRP_W  = 8;
  localparam int PDM_SUM_W  = 5;
  localparam int PDM_EVT_W  = 4;

  // ----------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------
  localparam logic [15:0] PDM_IDX_HEAD_PTR   = 16'h1A54;
  localparam logic [15:0] PDM_IDX_HEAD_FLAGS = 16'h1A55;
  localparam logic [15:0] PDM_IDX_NEXT_PTR   = 16'h1A56;
  localparam logic [15:0] PDM_IDX_NEXT_FLAGS = 16'h1A57;
  localparam logic [15:0] PDM_IDX_EVT_STAT   = 16'h1A58;
  localparam logic [15:0] PDM_IDX_EVT_MASK   = 16'h1A59;
  localparam logic [15:0] PDM_IDX_SUMMARY    = 16'h1A80;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int PDM_FLD_NO_ROOM = 7;
  localparam int PDM_FLD_PENULT  = 2;
  localparam int PDM_FLD_LAST    = 1;
  localparam int PDM_FLD_WRAP    = 0;

  localparam int PDM_SUM_TX     = 0;
  localparam int PDM_SUM_RX     = 1;
  localparam int PDM_SUM_RX_ERR = 2;
  localparam int PDM_SUM_PM     = 3;
  localparam int PDM_SUM_SOP    = 4;

  localparam int PDM_EVT_HEAD_WRAP = 0;
  localparam int PDM_EVT_NEXT_WRAP = 1;
  localparam int PDM_EVT_NO_ROOM   = 2;
  localparam int PDM_EVT_SUMMARY   = 3;

  // ----------------------------------------
  // Slots and reset values
  // ----------------------------------------
  localparam logic [PDM_PTR_W-1:0] PDM_SLOT_LAST   = 7'h7F;
  localparam logic [PDM_PTR_W-1:0] PDM_SLOT_PENULT = 7'h7E;
  localparam logic [PDM_PTR_W-1:0] PDM_RST_HEAD    = 7'h00;
  localparam logic [PDM_PTR_W-1:0] PDM_RST_NEXT    = 7'h01;
  localparam logic [PDM_PTR_W-1:0] PDM_STEP_ONE    = 7'h01;
  localparam logic [PDM_EVT_W-1:0] PDM_RST_EVT     = 4'h0;
  localparam logic [PDM_SUM_W-1:0] PDM_RST_SUM     = 5'h00;
  localparam logic [PDM_DATA_W-1:0] PDM_RST_DATA   = 32'h0000_0000;

  // Byte address of a register index
  function automatic logic [PDM_ADDR_W-1:0] pdm_byte_addr(input logic [15:0] idx);
    return {idx[13:0], 2'b00};
  endfunction

endpackage

// ===== core/pdm_ptr_step.sv
/*
  Modulo-128 pointer advance with wrap toggle.
  Assumes the step is below the RAM depth; purely combinational.
*/
`timescale 1ns/10ps
module pdm_ptr_step
  import pdm_pkg::*;
#(
  parameter int W = PDM_PTR_W
) (
  // Current pointer
  input  wire logic [W-1:0] ptr,
  input  wire logic         wrap,
  input  wire logic [W-1:0] step,
  // Advanced pointer
  output logic      [W-1:0] ptr_nxt,
  output logic              wrap_nxt
);

  logic [W:0] sum;

  // ----------------------------------------
  // Advance and wrap detect
  // ----------------------------------------
  always_comb begin
    sum      = {1'b0, ptr} + {1'b0, step};
    ptr_nxt  = sum[W-1:0];
    wrap_nxt = wrap ^ sum[W];
  end

endmodule

// ===== core/pdm_rx_ptr_summary.sv
/*
  Receive head-pointer flags, head-plus-one pointer, MAC event summary and
  a small event interrupt unit, reached over APB.
  Assumes the receive engine and group status registers run on pclk, that
  the read pointer is driven by pclk logic, and an APB master without pstrb.
*/
`timescale 1ns/10ps
module pdm_rx_ptr_summary
  import pdm_pkg::*;
#(
  parameter int PTR_W = PDM_PTR_W,
  parameter int GRP_W = PDM_GRP_W
) (
  // Clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // APB slave
  input  wire logic [PDM_ADDR_W-1:0] paddr,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [PDM_DATA_W-1:0] pwdata,
  output logic      [PDM_DATA_W-1:0] prdata,
  output logic                       pready,
  output logic                       pslverr,
  // Receive engine
  input  wire logic                  head_commit,
  input  wire logic [PTR_W-1:0]      head_commit_len,
  input  wire logic [PTR_W-1:0]      receive_read_pointer,
  output logic      [PTR_W-1:0]      head_pointer,
  output logic      [PTR_W-1:0]      head_next_pointer,
  // Group status and enables
  input  wire logic [GRP_W-1:0]      tx_status,
  input  wire logic [GRP_W-1:0]      tx_enable,
  input  wire logic [GRP_W-1:0]      rx_status,
  input  wire logic [GRP_W-1:0]      rx_enable,
  input  wire logic [GRP_W-1:0]      rx_err_status,
  input  wire logic [GRP_W-1:0]      rx_err_enable,
  input  wire logic [GRP_W-1:0]      pm_status,
  input  wire logic [GRP_W-1:0]      pm_enable,
  input  wire logic [GRP_W-1:0]      sop_status,
  input  wire logic [GRP_W-1:0]      sop_enable,
  // Event outputs
  output logic                       mac_event_line,
  output logic                       irq
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [PTR_W-1:0]      head_ptr_r;
  logic                  head_wrap_r;
  logic [PTR_W-1:0]      next_ptr_r;
  logic                  next_wrap_r;
  logic [PDM_EVT_W-1:0]  evt_stat_r;
  logic [PDM_EVT_W-1:0]  evt_mask_r;
  logic [PDM_EVT_W-1:0]  evt_stat_nxt;
  logic [PDM_EVT_W-1:0]  evt_set;
  logic [PDM_DATA_W-1:0] prdata_r;
  logic                  pready_r;
  logic                  pslverr_r;
  logic                  irq_r;
  logic                  mac_line_r;
  logic                  no_room_q;
  logic                  mac_line_q;

  logic [PDM_SUM_W-1:0]  summary;
  logic [PTR_W-1:0]      head_step_ptr;
  logic                  head_step_wrap;
  logic [PTR_W-1:0]      next_step_ptr;
  logic                  next_step_wrap;

  logic                  setup_phase;
  logic                  wr_take;
  logic                  wr_head_ptr;
  logic                  wr_head_flags;
  logic                  wr_next_ptr;
  logic                  wr_next_flags;
  logic                  wr_evt_stat;
  logic                  wr_evt_mask;
  logic                  sw_ptr_write;
  logic                  hw_step;

  logic                  header_space_lacking;
  logic                  head_at_penultimate_slot;
  logic                  head_at_last_slot;
  logic [PDM_DATA_W-1:0] rd_data;
  logic                  rd_known;

  // Address match against a register index
  function automatic logic addr_is(input logic [PDM_ADDR_W-1:0] a, input logic [15:0] idx);
    return a == pdm_byte_addr(idx);
  endfunction

  // ----------------------------------------
  // Submodules
  // ----------------------------------------
  pdm_ptr_step #(
    .W        (PTR_W)
  ) u_head_step (
    .ptr      (head_ptr_r),
    .wrap     (head_wrap_r),
    .step     (head_commit_len),
    .ptr_nxt  (head_step_ptr),
    .wrap_nxt (head_step_wrap)
  );

  pdm_ptr_step #(
    .W        (PTR_W)
  ) u_next_step (
    .ptr      (next_ptr_r),
    .wrap     (next_wrap_r),
    .step     (head_commit_len),
    .ptr_nxt  (next_step_ptr),
    .wrap_nxt (next_step_wrap)
  );

  pdm_event_summary #(
    .GW            (GRP_W)
  ) u_summary (
    .pclk          (pclk),
    .presetn       (presetn),
    .tx_status     (tx_status),
    .tx_enable     (tx_enable),
    .rx_status     (rx_status),
    .rx_enable     (rx_enable),
    .rx_err_status (rx_err_status),
    .rx_err_enable (rx_err_enable),
    .pm_status     (pm_status),
    .pm_enable     (pm_enable),
    .sop_status    (sop_status),
    .sop_enable    (sop_enable),
    .summary       (summary)
  );

  // ----------------------------------------
  // Write decode
  // ----------------------------------------
  assign setup_phase   = psel & ~penable;
  assign wr_take       = psel & penable & pready_r & pwrite;
  assign wr_head_ptr   = wr_take & addr_is(paddr, PDM_IDX_HEAD_PTR);
  assign wr_head_flags = wr_take & addr_is(paddr, PDM_IDX_HEAD_FLAGS);
  assign wr_next_ptr   = wr_take & addr_is(paddr, PDM_IDX_NEXT_PTR);
  assign wr_next_flags = wr_take & addr_is(paddr, PDM_IDX_NEXT_FLAGS);
  assign wr_evt_stat   = wr_take & addr_is(paddr, PDM_IDX_EVT_STAT);
  assign wr_evt_mask   = wr_take & addr_is(paddr, PDM_IDX_EVT_MASK);
  assign sw_ptr_write  = wr_head_ptr | wr_head_flags | wr_next_ptr | wr_next_flags;
  // Software write wins over a commit in the same cycle
  assign hw_step       = head_commit & ~sw_ptr_write;

  // ----------------------------------------
  // Head pointer and wrap
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      head_ptr_r <= PDM_RST_HEAD;
    end else if (wr_head_ptr) begin
      head_ptr_r <= pwdata[PTR_W-1:0];
    end else if (hw_step) begin
      head_ptr_r <= head_step_ptr;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      head_wrap_r <= 1'b0;
    end else if (wr_head_flags) begin
      head_wrap_r <= pwdata[PDM_FLD_WRAP];
    end else if (hw_step) begin
      head_wrap_r <= head_step_wrap;
    end
  end

  // ----------------------------------------
  // Head-plus-one pointer and wrap
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      next_ptr_r <= PDM_RST_NEXT;
    end else if (wr_next_ptr) begin
      next_ptr_r <= pwdata[PTR_W-1:0];
    end else if (hw_step) begin
      next_ptr_r <= next_step_ptr;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      next_wrap_r <= 1'b0;
    end else if (wr_next_flags) begin
      next_wrap_r <= pwdata[PDM_FLD_WRAP];
    end else if (hw_step) begin
      next_wrap_r <= next_step_wrap;
    end
  end

  // ----------------------------------------
  // Slot and space flags
  // ----------------------------------------
  always_comb begin
    head_at_last_slot        = head_ptr_r == PDM_SLOT_LAST;
    head_at_penultimate_slot = head_ptr_r == PDM_SLOT_PENULT;
    header_space_lacking     = (head_ptr_r == receive_read_pointer) |
                               (next_ptr_r == receive_read_pointer);
  end

  // ----------------------------------------
  // Event status, mask and interrupt
  // ----------------------------------------
  always_comb begin
    evt_set                    = PDM_RST_EVT;
    evt_set[PDM_EVT_HEAD_WRAP] = hw_step & (head_step_wrap ^ head_wrap_r);
    evt_set[PDM_EVT_NEXT_WRAP] = hw_step & (next_step_wrap ^ next_wrap_r);
    evt_set[PDM_EVT_NO_ROOM]   = header_space_lacking & ~no_room_q;
    evt_set[PDM_EVT_SUMMARY]   = mac_line_r & ~mac_line_q;
    evt_stat_nxt               = evt_stat_r;
    if (wr_evt_stat) begin
      evt_stat_nxt = evt_stat_r & ~pwdata[PDM_EVT_W-1:0];
    end
    // Set wins over a clear in the same cycle
    evt_stat_nxt = evt_stat_nxt | evt_set;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_stat_r <= PDM_RST_EVT;
    end else begin
      evt_stat_r <= evt_stat_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_mask_r <= PDM_RST_EVT;
    end else if (wr_evt_mask) begin
      evt_mask_r <= pwdata[PDM_EVT_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      no_room_q  <= 1'b0;
      mac_line_q <= 1'b0;
    end else begin
      no_room_q  <= header_space_lacking;
      mac_line_q <= mac_line_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(evt_stat_nxt & evt_mask_r);
    end
  end

  // ----------------------------------------
  // MAC event line
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mac_line_r <= 1'b0;
    end else begin
      mac_line_r <= |summary;
    end
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  always_comb begin
    rd_data  = PDM_RST_DATA;
    rd_known = 1'b1;
    if (addr_is(paddr, PDM_IDX_HEAD_PTR)) begin
      rd_data[PTR_W-1:0] = head_ptr_r;
    end else if (addr_is(paddr, PDM_IDX_HEAD_FLAGS)) begin
      rd_data[PDM_FLD_NO_ROOM] = header_space_lacking;
      rd_data[PDM_FLD_PENULT]  = head_at_penultimate_slot;
      rd_data[PDM_FLD_LAST]    = head_at_last_slot;
      rd_data[PDM_FLD_WRAP]    = head_wrap_r;
    end else if (addr_is(paddr, PDM_IDX_NEXT_PTR)) begin
      rd_data[PTR_W-1:0] = next_ptr_r;
    end else if (addr_is(paddr, PDM_IDX_NEXT_FLAGS)) begin
      rd_data[PDM_FLD_WRAP] = next_wrap_r;
    end else if (addr_is(paddr, PDM_IDX_EVT_STAT)) begin
      rd_data[PDM_EVT_W-1:0] = evt_stat_r;
    end else if (addr_is(paddr, PDM_IDX_EVT_MASK)) begin
      rd_data[PDM_EVT_W-1:0] = evt_mask_r;
    end else if (addr_is(paddr, PDM_IDX_SUMMARY)) begin
      // Read only; writes here are accepted and dropped
      rd_data[PDM_SUM_W-1:0] = summary;
    end else begin
      rd_known = 1'b0;
    end
  end

  // ----------------------------------------
  // APB answer
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
    end else begin
      pready_r <= setup_phase;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_r <= 1'b0;
    end else begin
      pslverr_r <= setup_phase & ~rd_known;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= PDM_RST_DATA;
    end else if (setup_phase & ~pwrite) begin
      prdata_r <= rd_data;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign prdata            = prdata_r;
  assign pready            = pready_r;
  assign pslverr           = pslverr_r;
  assign head_pointer      = head_ptr_r;
  assign head_next_pointer = next_ptr_r;
  assign mac_event_line    = mac_line_r;
  assign irq               = irq_r;

endmodule

// ===== tb/pdm_rx_ptr_summary_monitor.sv
/*
  Port-level checker for the head-pointer flags and event summary block.
  Assumes binding to pdm_rx_ptr_summary in one pclk domain.
*/
`timescale 1ns/10ps
module pdm_rx_ptr_summary_monitor
  import pdm_pkg::*;
#(
  parameter int PTR_W = PDM_PTR_W,
  parameter int GRP_W = PDM_GRP_W
) (
  // Clock and APB
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire logic [PDM_ADDR_W-1:0] paddr,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [PDM_DATA_W-1:0] prdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  // Receive side
  input wire logic                  head_commit,
  input wire logic [PTR_W-1:0]      head_commit_len,
  input wire logic [PTR_W-1:0]      head_pointer,
  input wire logic [PTR_W-1:0]      head_next_pointer,
  // Groups
  input wire logic [GRP_W-1:0]      tx_status,
  input wire logic [GRP_W-1:0]      tx_enable,
  input wire logic [GRP_W-1:0]      rx_status,
  input wire logic [GRP_W-1:0]      rx_enable,
  input wire logic [GRP_W-1:0]      rx_err_status,
  input wire logic [GRP_W-1:0]      rx_err_enable,
  input wire logic [GRP_W-1:0]      pm_status,
  input wire logic [GRP_W-1:0]      pm_enable,
  input wire logic [GRP_W-1:0]      sop_status,
  input wire logic [GRP_W-1:0]      sop_enable,
  input wire logic                  mac_event_line
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic hw_wr;
  logic mapped;
  logic grp_any;
  assign hw_wr = psel && penable && pwrite;
  assign mapped = paddr inside {{PDM_IDX_HEAD_PTR[13:0], 2'b00}, {PDM_IDX_HEAD_FLAGS[13:0], 2'b00},
    {PDM_IDX_NEXT_PTR[13:0], 2'b00}, {PDM_IDX_NEXT_FLAGS[13:0], 2'b00},
    {PDM_IDX_EVT_STAT[13:0], 2'b00}, {PDM_IDX_EVT_MASK[13:0], 2'b00},
    {PDM_IDX_SUMMARY[13:0], 2'b00}};
  assign grp_any = |((tx_status & tx_enable) | (rx_status & rx_enable) | (pm_status & pm_enable)
    | (rx_err_status & rx_err_enable) | (sop_status & sop_enable));
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_commit;
    head_commit && !hw_wr;
  endsequence
  a_head_advance: assert property (s_commit |=>
    head_pointer == $past(head_pointer) + $past(head_commit_len)) else $error("head step off");
  a_next_ahead: assert property (s_commit |=>
    head_next_pointer == $past(head_next_pointer) + $past(head_commit_len))
    else $error("plus-one step off");
  a_ptr_hold: assert property (!head_commit && !hw_wr |=>
    $stable(head_pointer) && $stable(head_next_pointer)) else $error("pointer moved");
  a_line_follows: assert property (mac_event_line == $past(grp_any, 2))
    else $error("event line off");
  a_ready_after: assert property (s_setup |=> pready) else $error("no ready");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready too long");
  a_err_decode: assert property (s_setup |=> pslverr == !$past(mapped)) else $error("bad error");
  a_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
  a_err_rdata: assert property (pslverr && !pwrite |-> prdata == '0) else $error("error data");
endmodule

// ===== tb/tb_top.sv
/*
  Directed testbench for pdm_rx_ptr_summary.
  Assumes the monitor is compiled alongside; the master waits for pready however long it takes.
*/
`timescale 1ns/10ps
module tb_top;
  import pdm_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        head_commit, mac_event_line, irq, er;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [6:0]  head_commit_len, rp, head_pointer, head_next_pointer;
  logic [7:0]  gs [5];
  logic [7:0]  ge [5];
  int          fails, compares;

  pdm_rx_ptr_summary u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .head_commit(head_commit), .head_commit_len(head_commit_len),
    .receive_read_pointer(rp), .head_pointer(head_pointer),
    .head_next_pointer(head_next_pointer), .tx_status(gs[0]), .tx_enable(ge[0]),
    .rx_status(gs[1]), .rx_enable(ge[1]), .rx_err_status(gs[2]), .rx_err_enable(ge[2]),
    .pm_status(gs[3]), .pm_enable(ge[3]), .sop_status(gs[4]), .sop_enable(ge[4]),
    .mac_event_line(mac_event_line), .irq(irq));

  always #5 pclk = ~pclk;

  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task apb(input logic wr, input logic [15:0] idx, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= {idx[13:0], 2'b00};
    pwrite  <= wr;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(negedge pclk);
  endtask

  task rdc(input logic [15:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(rd, exp);
  endtask

  task commit(input logic [6:0] len);
    @(posedge pclk);
    head_commit <= 1'b1; head_commit_len <= len;
    @(posedge pclk);
    head_commit <= 1'b0;
    @(negedge pclk);
  endtask

  task settle();
    repeat (3) @(negedge pclk);
  endtask

  task s_reset();
    chk(head_next_pointer, 7'h01);
    chk(head_pointer, 7'h00);
    rdc(PDM_IDX_HEAD_PTR, 32'h00);
    rdc(PDM_IDX_HEAD_FLAGS, 32'h80);
    rdc(PDM_IDX_NEXT_PTR, 32'h01);
    rdc(PDM_IDX_NEXT_FLAGS, 32'h00);
    rdc(PDM_IDX_SUMMARY, 32'h00);
  endtask

  task s_ptrs();
    @(posedge pclk) rp <= 7'h40;
    apb(1'b1, PDM_IDX_HEAD_PTR, 32'h7C);
    chk(head_pointer, 7'h7C);
    apb(1'b1, PDM_IDX_NEXT_PTR, 32'hFD);
    rdc(PDM_IDX_NEXT_PTR, 32'h7D);
    commit(7'h02);
    chk(head_pointer, 7'h7E);
    rdc(PDM_IDX_HEAD_FLAGS, 32'h04);
    commit(7'h01);
    rdc(PDM_IDX_HEAD_FLAGS, 32'h02);
    chk(head_next_pointer, 7'h00);
    rdc(PDM_IDX_NEXT_FLAGS, 32'h01);
    commit(7'h03);
    chk(head_pointer, 7'h02);
    rdc(PDM_IDX_HEAD_FLAGS, 32'h01);
    rdc(PDM_IDX_NEXT_FLAGS, 32'h01);
    apb(1'b1, PDM_IDX_HEAD_FLAGS, 32'hFE);
    rdc(PDM_IDX_HEAD_FLAGS, 32'h00);
    apb(1'b1, PDM_IDX_NEXT_FLAGS, 32'hFE);
    rdc(PDM_IDX_NEXT_FLAGS, 32'h00);
  endtask

  task s_irq();
    rdc(PDM_IDX_EVT_STAT, 32'h07);
    apb(1'b1, PDM_IDX_EVT_MASK, 32'h01);
    settle();
    chk(irq, 1'b1);
    apb(1'b1, PDM_IDX_EVT_MASK, 32'h00);
    settle();
    chk(irq, 1'b0);
    apb(1'b1, PDM_IDX_EVT_STAT, 32'h07);
    rdc(PDM_IDX_EVT_STAT, 32'h00);
    apb(1'b1, PDM_IDX_EVT_MASK, 32'h09);
    settle();
    chk(irq, 1'b0);
  endtask

  task s_room();
    @(posedge pclk) rp <= 7'h03;
    rdc(PDM_IDX_HEAD_FLAGS, 32'h80);
    @(posedge pclk) rp <= 7'h02;
    rdc(PDM_IDX_HEAD_FLAGS, 32'h80);
    @(posedge pclk) rp <= 7'h41;
    rdc(PDM_IDX_HEAD_FLAGS, 32'h00);
  endtask

  task s_sum();
    for (int i = 0; i < 5; i++) begin
      @(posedge pclk);
      gs[i] <= 8'h81; ge[i] <= 8'h7E;
      settle();
      chk(mac_event_line, 1'b0);
      rdc(PDM_IDX_SUMMARY, 32'h00);
      @(posedge pclk) ge[i] <= 8'h01;
      settle();
      chk(mac_event_line, 1'b1);
      @(negedge pclk);
      chk(irq, 1'b1);
      apb(1'b1, PDM_IDX_SUMMARY, 32'h00);
      chk(er, 1'b0);
      rdc(PDM_IDX_SUMMARY, 32'h1 << i);
      @(posedge pclk) ge[i] <= 8'h00;
      settle();
      chk(mac_event_line, 1'b0);
      @(posedge pclk) ge[i] <= 8'h01;
      @(posedge pclk) gs[i] <= 8'h00;
      settle();
      chk(mac_event_line, 1'b0);
      rdc(PDM_IDX_SUMMARY, 32'h00);
      apb(1'b1, PDM_IDX_EVT_STAT, 32'h08);
      settle();
      chk(irq, 1'b0);
    end
  endtask

  task s_bad();
    apb(1'b0, 16'h1A5A, 32'h0);
    chk(er, 1'b1);
    chk(rd, 32'h0);
    apb(1'b1, 16'h1A7F, 32'hFF);
    chk(er, 1'b1);
  endtask

  task close_out();
    $display("comparisons %0d mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = '0; pwdata = '0;
    head_commit = 0; head_commit_len = '0; rp = '0; fails = 0; compares = 0;
    for (int i = 0; i < 5; i++) begin
      gs[i] = '0;
      ge[i] = '0;
    end
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    s_reset();
    s_ptrs();
    s_irq();
    s_room();
    s_sum();
    s_bad();
    @(posedge pclk);
    presetn <= 1'b0;
    rp      <= 7'h00;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    s_reset();
    close_out();
  end

  initial begin
    #50000;
    fails++;
    close_out();
  end
endmodule

bind pdm_rx_ptr_summary pdm_rx_ptr_summary_monitor #(.PTR_W(PTR_W), .GRP_W(GRP_W)) u_mon (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .head_commit(head_commit), .head_commit_len(head_commit_len), .head_pointer(head_pointer),
  .head_next_pointer(head_next_pointer), .tx_status(tx_status), .tx_enable(tx_enable),
  .rx_status(rx_status), .rx_enable(rx_enable), .rx_err_status(rx_err_status),
  .rx_err_enable(rx_err_enable), .pm_status(pm_status), .pm_enable(pm_enable),
  .sop_status(sop_status), .sop_enable(sop_enable), .mac_event_line(mac_event_line));
